// ### cycle_timer_pkg.sv
// Constants, types and register map for the scan-cycle scheduler and settings panel
package cycle_timer_pkg;
	localparam int unsigned CLK_HZ = 25_000_000; // System clock rate, Hz
	localparam int unsigned TIMEOUT_S = 20; // Settings inactivity timeout, seconds
	localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ; // Exact product, 500,000,000 clocks
	localparam int unsigned MS_CYCLES = CLK_HZ / 1000; // Clocks per millisecond
	localparam logic [7:0] CYC_MIN_MS = 8'h64; // 100 ms shortest cycle
	localparam logic [7:0] CYC_STEP_MS = 8'h05; // 5 ms per step
	localparam logic [4:0] CYC_IDX_MAX = 5'h1e; // (250 - 100) / 5 steps
	localparam logic [4:0] CYC_IDX_DEFAULT = 5'h14; // 200 ms
	localparam logic [4:0] ADDR_LOCAL = 5'h01; // Local terminal only
	localparam logic [4:0] ADDR_MAX = 5'h1e; // Highest station address, 30
	localparam logic [4:0] ADDR_DEFAULT = 5'h01; // Shown as 01 out of reset
	localparam logic [2:0] RATE_MAX = 3'h7; // Eight selectable line rates
	localparam logic [2:0] RATE_DEFAULT = 3'h6; // Default line rate index
	localparam logic [3:0] TEN_LAST = 4'h9; // Cycles per indicator blink, minus one
	localparam int unsigned PHASES = 5; // Steps of one scan cycle
	localparam int unsigned ADDR_W = 6; // AXI address bits decoded
	// Register byte offsets
	localparam logic [5:0] OFS_SETTINGS = 6'h00;
	localparam logic [5:0] OFS_COMM_CFG = 6'h04;
	localparam logic [5:0] OFS_STATUS = 6'h08;
	localparam logic [5:0] OFS_CYCLES = 6'h0c;
	// Field positions
	localparam int unsigned F_ADDR_LSB = 0;
	localparam int unsigned F_RATE_LSB = 8;
	localparam int unsigned F_CYC_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Key bit positions in the key vector
	localparam int unsigned K_PAGE = 0;
	localparam int unsigned K_UP = 1;
	localparam int unsigned K_DOWN = 2;
	localparam int unsigned K_CONFIRM = 3;
	localparam int unsigned K_TOGGLE = 4;
	localparam int unsigned K_PROTECT = 5;
	localparam int unsigned KEYS = 6;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_ARMED, MODE_SETTINGS} mode_t;
	typedef enum logic [1:0] {PAGE_ADDR, PAGE_RATE, PAGE_CYCLE} page_t;
	// Programmed settings held together
	typedef struct packed {
		logic [4:0] cyc_idx;
		logic [2:0] rate;
		logic [4:0] addr;
	} settings_t;
	localparam settings_t SETTINGS_RESET = '{cyc_idx: CYC_IDX_DEFAULT, rate: RATE_DEFAULT,
		addr: ADDR_DEFAULT};
endpackage : cycle_timer_pkg

// ### cycle_timer_and_comm_setup.sv
// Scan-cycle scheduler, settings panel and AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module cycle_timer_and_comm_setup #(
	parameter int unsigned TIMEOUT_CYCLES = cycle_timer_pkg::TIMEOUT_CYCLES,
	parameter int unsigned MS_CYCLES = cycle_timer_pkg::MS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic page_key,
	input wire logic up_key,
	input wire logic down_key,
	input wire logic confirm_key,
	input wire logic settings_toggle_key,
	input wire logic memory_protect_switch,
	output logic cycle_period_indicator,
	output logic [4:0] phase_strobe,
	output logic [4:0] station_address,
	output logic [2:0] line_rate_sel,
	output logic serve_terminal,
	output logic serve_network,
	output logic settings_active,
	output logic [1:0] display_page,
	output logic [7:0] display_value
);
	// Decode a byte address: {hit, word index}
	function automatic logic [2:0] decode(input logic [5:0] a);
		decode = {(a[5:4] == 2'h0) && (a[1:0] == 2'h0), a[3:2]};
	endfunction : decode
	// Keep an address inside the legal station range
	function automatic logic [4:0] clamp_addr(input logic [4:0] a);
		clamp_addr = (a < cycle_timer_pkg::ADDR_LOCAL) ? cycle_timer_pkg::ADDR_LOCAL :
			(a > cycle_timer_pkg::ADDR_MAX) ? cycle_timer_pkg::ADDR_MAX : a;
	endfunction : clamp_addr

	// Key synchronisers and edge detection
	logic [5:0] key_pins; // Raw panel pins
	logic [5:0] key_s1_q; // First stage, read only by the second
	logic [5:0] key_s2_q; // Synchronised level
	logic [5:0] key_s3_q; // Previous level for edges
	logic [5:0] press; // One-cycle press pulses
	assign key_pins = {memory_protect_switch, settings_toggle_key, confirm_key, down_key,
		up_key, page_key};
	assign press = key_s2_q & ~key_s3_q;
	// Pins come from outside the clock domain, so two flops before use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			key_s1_q <= 6'h00;
			key_s2_q <= 6'h00;
			key_s3_q <= 6'h00;
		end
		else
		begin
			key_s1_q <= key_pins;
			key_s2_q <= key_s1_q;
			key_s3_q <= key_s2_q;
		end
	end

	// Settings mode state
	cycle_timer_pkg::mode_t mode_q, mode_d; // Panel mode
	cycle_timer_pkg::page_t page_q, page_d; // Shown setting page
	cycle_timer_pkg::settings_t set_q, set_d; // Programmed settings
	logic force_q, force_d; // Address forced to local
	logic [31:0] idle_q; // Clocks since last key activity
	logic timeout; // Inactivity limit reached
	logic any_key; // Any panel or toggle press
	logic confirm_held; // Confirm key level
	logic addr_page; // Address page active in settings
	logic [4:0] eff_addr; // Address actually in use
	logic local_only; // Local terminal selected
	logic [3:0] comm_cfg_q; // Block presence and order flags
	logic comm_ok; // Configuration permits communication
	logic sw_set_we; // Software writes the settings word
	logic [31:0] sw_set_val; // Merged settings write value
	assign any_key = |press[cycle_timer_pkg::K_TOGGLE:cycle_timer_pkg::K_PAGE];
	assign confirm_held = key_s2_q[cycle_timer_pkg::K_CONFIRM];
	assign timeout = (idle_q == TIMEOUT_CYCLES - 1);
	assign addr_page = (mode_q == cycle_timer_pkg::MODE_SETTINGS) &&
		(page_q == cycle_timer_pkg::PAGE_ADDR);
	assign eff_addr = force_q ? cycle_timer_pkg::ADDR_LOCAL : set_q.addr;
	assign local_only = (eff_addr == cycle_timer_pkg::ADDR_LOCAL);
	assign comm_ok = &comm_cfg_q;

	// Mode, page and key-driven setting changes
	always_comb
	begin
		mode_d = mode_q;
		page_d = page_q;
		set_d = set_q;
		force_d = force_q;
		case (mode_q)
			cycle_timer_pkg::MODE_NORMAL:
			begin
				// Entry only with the protect switch in the writable position
				if (press[cycle_timer_pkg::K_TOGGLE] && key_s2_q[cycle_timer_pkg::K_PROTECT])
					mode_d = cycle_timer_pkg::MODE_ARMED;
			end
			cycle_timer_pkg::MODE_ARMED:
			begin
				if (timeout || press[cycle_timer_pkg::K_TOGGLE])
					mode_d = cycle_timer_pkg::MODE_NORMAL;
				else if (press[cycle_timer_pkg::K_CONFIRM])
				begin
					mode_d = cycle_timer_pkg::MODE_SETTINGS;
					page_d = cycle_timer_pkg::PAGE_ADDR;
				end
			end
			cycle_timer_pkg::MODE_SETTINGS:
			begin
				if (timeout || press[cycle_timer_pkg::K_TOGGLE])
					mode_d = cycle_timer_pkg::MODE_NORMAL;
				else if (press[cycle_timer_pkg::K_PAGE])
					page_d = (page_q == cycle_timer_pkg::PAGE_CYCLE) ?
						cycle_timer_pkg::PAGE_ADDR : cycle_timer_pkg::page_t'(page_q + 2'h1);
				else if (page_q == cycle_timer_pkg::PAGE_ADDR && confirm_held)
				begin
					if (press[cycle_timer_pkg::K_DOWN])
						force_d = 1'b1;
					else if (press[cycle_timer_pkg::K_UP])
						force_d = 1'b0;
				end
				else if (page_q == cycle_timer_pkg::PAGE_ADDR)
				begin
					// Stops at either end rather than wrapping
					if (press[cycle_timer_pkg::K_UP] && set_q.addr < cycle_timer_pkg::ADDR_MAX)
						set_d.addr = set_q.addr + 5'h01;
					else if (press[cycle_timer_pkg::K_DOWN] && set_q.addr > cycle_timer_pkg::ADDR_LOCAL)
						set_d.addr = set_q.addr - 5'h01;
				end
				else if (page_q == cycle_timer_pkg::PAGE_RATE)
				begin
					if (press[cycle_timer_pkg::K_UP] && set_q.rate < cycle_timer_pkg::RATE_MAX)
						set_d.rate = set_q.rate + 3'h1;
					else if (press[cycle_timer_pkg::K_DOWN] && set_q.rate > 3'h0)
						set_d.rate = set_q.rate - 3'h1;
				end
				else
				begin
					if (press[cycle_timer_pkg::K_UP] && set_q.cyc_idx < cycle_timer_pkg::CYC_IDX_MAX)
						set_d.cyc_idx = set_q.cyc_idx + 5'h01;
					else if (press[cycle_timer_pkg::K_DOWN] && set_q.cyc_idx > 5'h00)
						set_d.cyc_idx = set_q.cyc_idx - 5'h01;
				end
			end
			default:
				mode_d = cycle_timer_pkg::MODE_NORMAL;
		endcase
		// A software write replaces the settings, clamped into range
		if (sw_set_we)
		begin
			set_d.addr = clamp_addr(sw_set_val[cycle_timer_pkg::F_ADDR_LSB +: 5]);
			set_d.rate = sw_set_val[cycle_timer_pkg::F_RATE_LSB +: 3];
			set_d.cyc_idx = (sw_set_val[cycle_timer_pkg::F_CYC_LSB +: 5] >
				cycle_timer_pkg::CYC_IDX_MAX) ? cycle_timer_pkg::CYC_IDX_MAX :
				sw_set_val[cycle_timer_pkg::F_CYC_LSB +: 5];
		end
	end

	// Settings registers; 200 ms period from reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_q <= cycle_timer_pkg::MODE_NORMAL;
			page_q <= cycle_timer_pkg::PAGE_ADDR;
			set_q <= cycle_timer_pkg::SETTINGS_RESET;
			force_q <= 1'b0;
			idle_q <= 32'h0;
		end
		else
		begin
			mode_q <= mode_d;
			page_q <= page_d;
			set_q <= set_d;
			force_q <= force_d;
			// Any key restarts the idle count; normal mode holds it at zero
			idle_q <= (any_key || mode_q == cycle_timer_pkg::MODE_NORMAL) ? 32'h0 :
				idle_q + 32'h1;
		end
	end

	// Scan-cycle timer
	logic [31:0] ms_cnt_q; // Clocks within the current millisecond
	logic [7:0] cyc_ms_q; // Milliseconds within the current cycle
	logic [7:0] period_ms; // Programmed period in ms
	logic ms_tick; // Last clock of a millisecond
	logic cycle_end; // Last clock of a cycle
	logic [3:0] ten_q; // Cycles modulo ten
	logic [4:0] strobe_q; // Phase strobes in order
	logic [31:0] cycles_q; // Completed cycle count
	logic led_q; // Indicator level
	assign period_ms = cycle_timer_pkg::CYC_MIN_MS +
		8'(cycle_timer_pkg::CYC_STEP_MS * set_q.cyc_idx);
	assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);
	assign cycle_end = ms_tick && (cyc_ms_q == period_ms - 8'h01);
	// A period change takes effect at once; a long count already past it wraps safely
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ms_cnt_q <= 32'h0;
			cyc_ms_q <= 8'h00;
			ten_q <= 4'h0;
			strobe_q <= 5'h00;
			cycles_q <= 32'h0;
			led_q <= 1'b0;
		end
		else
		begin
			ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
			if (cycle_end || (ms_tick && cyc_ms_q >= period_ms))
				cyc_ms_q <= 8'h00;
			else if (ms_tick)
				cyc_ms_q <= cyc_ms_q + 8'h01;
			// One strobe per phase on consecutive clocks after each cycle boundary
			strobe_q <= {strobe_q[3:0], cycle_end};
			if (cycle_end)
			begin
				ten_q <= (ten_q == cycle_timer_pkg::TEN_LAST) ? 4'h0 : ten_q + 4'h1;
				led_q <= (ten_q == cycle_timer_pkg::TEN_LAST);
				cycles_q <= cycles_q + 32'h1;
			end
		end
	end

	// Panel display, registered
	logic [7:0] disp_q; // Value shown for the current page
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			disp_q <= 8'h00;
		else if (page_q == cycle_timer_pkg::PAGE_RATE)
			disp_q <= {5'h00, set_q.rate};
		else if (page_q == cycle_timer_pkg::PAGE_CYCLE)
			disp_q <= period_ms;
		else
			disp_q <= {3'h0, eff_addr};
	end

	// AXI4-Lite write path; address and data may arrive in either order
	logic aw_hold_q, w_hold_q, bvalid_q; // Held request halves and response
	logic [5:0] awaddr_q; // Held write address
	logic [31:0] wdata_q; // Held write data
	logic [3:0] wstrb_q; // Held byte enables
	logic [1:0] bresp_q; // Write response code
	logic commit; // Both halves present
	logic [2:0] wdec; // Write decode
	logic [31:0] wmask; // Byte-lane mask
	logic [31:0] set_word; // Current settings as read
	assign commit = aw_hold_q && w_hold_q && !bvalid_q;
	assign wdec = decode(awaddr_q);
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign set_word = {11'h000, set_q.cyc_idx, 5'h00, set_q.rate, 3'h0, set_q.addr};
	assign sw_set_we = commit && wdec[2] && (wdec[1:0] == cycle_timer_pkg::OFS_SETTINGS[3:2]);
	assign sw_set_val = (set_word & ~wmask) | (wdata_q & wmask);
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	// The device only answers the master, it never initiates
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= cycle_timer_pkg::RESP_OKAY;
			awaddr_q <= 6'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			comm_cfg_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (commit)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wdec[2] ? cycle_timer_pkg::RESP_OKAY : cycle_timer_pkg::RESP_SLVERR;
				if (wdec[2] && wdec[1:0] == cycle_timer_pkg::OFS_COMM_CFG[3:2] && wstrb_q[0])
					comm_cfg_q <= wdata_q[3:0];
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// AXI4-Lite read path
	logic rvalid_q; // Read data valid
	logic [31:0] rdata_q; // Read data
	logic [1:0] rresp_q; // Read response
	logic [2:0] rdec; // Read decode
	logic [31:0] rmux; // Selected read word
	logic [31:0] status_word; // Live status
	assign rdec = decode(s_axi_araddr);
	assign status_word = {19'h0, 1'b0, display_page, mode_q, comm_ok, serve_network,
		serve_terminal, eff_addr};
	assign rmux = (rdec[1:0] == cycle_timer_pkg::OFS_SETTINGS[3:2]) ? set_word :
		(rdec[1:0] == cycle_timer_pkg::OFS_COMM_CFG[3:2]) ? {28'h0, comm_cfg_q} :
		(rdec[1:0] == cycle_timer_pkg::OFS_STATUS[3:2]) ? status_word : cycles_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= cycle_timer_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rdec[2] ? rmux : 32'h0;
			rresp_q <= rdec[2] ? cycle_timer_pkg::RESP_OKAY : cycle_timer_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// Outputs; the effective address picks which party is served, and neither is unless all four block flags are set
	assign serve_terminal = comm_ok && local_only;
	assign serve_network = comm_ok && !local_only;
	assign station_address = eff_addr;
	assign line_rate_sel = set_q.rate;
	assign cycle_period_indicator = led_q;
	assign phase_strobe = strobe_q;
	assign settings_active = (mode_q == cycle_timer_pkg::MODE_SETTINGS);
	assign display_page = page_q;
	assign display_value = disp_q;

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_phases;
		phase_strobe[1] ##1 phase_strobe[2] ##1 phase_strobe[3] ##1 phase_strobe[4];
	endsequence
	sequence s_force_req;
		addr_page && confirm_held && press[cycle_timer_pkg::K_DOWN] && !timeout &&
			!press[cycle_timer_pkg::K_TOGGLE] && !press[cycle_timer_pkg::K_PAGE];
	endsequence
	sequence s_restore_req;
		addr_page && confirm_held && press[cycle_timer_pkg::K_UP] && !press[cycle_timer_pkg::K_DOWN] &&
			!timeout && !press[cycle_timer_pkg::K_TOGGLE] && !press[cycle_timer_pkg::K_PAGE];
	endsequence
	property p_addr_range;
		set_q.addr >= cycle_timer_pkg::ADDR_LOCAL && set_q.addr <= cycle_timer_pkg::ADDR_MAX;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("address out of range");
	property p_period_range;
		period_ms >= 8'h64 && period_ms <= 8'hfa && (period_ms - 8'h64) % 8'h05 == 8'h00;
	endproperty
	a_period_range: assert property (p_period_range) else $error("period off grid");
	property p_blink;
		$rose(cycle_period_indicator) |-> $past(ten_q) == 4'h9 && $past(cycle_end);
	endproperty
	a_blink: assert property (p_blink) else $error("indicator not on tenth cycle");
	property p_phases;
		phase_strobe[0] |=> s_phases;
	endproperty
	a_phases: assert property (p_phases) else $error("phase order broken");
	property p_force;
		s_force_req |=> eff_addr == 5'h01 ##1 display_value == 8'h01;
	endproperty
	a_force: assert property (p_force) else $error("address not forced to local");
	property p_restore;
		s_restore_req |=> eff_addr == set_q.addr ##1 display_value == {3'h0, $past(set_q.addr)};
	endproperty
	a_restore: assert property (p_restore) else $error("address not restored");
	property p_exclusive;
		!(serve_terminal && serve_network) && (!serve_terminal || station_address == 5'h01);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("both parties served");
	property p_comm_gate;
		(serve_terminal || serve_network) |-> comm_cfg_q == 4'hf;
	endproperty
	a_comm_gate: assert property (p_comm_gate) else $error("serving without blocks");
	property p_entry;
		$rose(settings_active) |-> $past(mode_q) == cycle_timer_pkg::MODE_ARMED &&
			$past(press[cycle_timer_pkg::K_CONFIRM]);
	endproperty
	a_entry: assert property (p_entry) else $error("settings entered wrongly");
	property p_timeout;
		(mode_q != cycle_timer_pkg::MODE_NORMAL && timeout) |=> !settings_active;
	endproperty
	a_timeout: assert property (p_timeout) else $error("no inactivity exit");
endmodule : cycle_timer_and_comm_setup
`default_nettype wire

// ### cycle_timer_master_model.sv
// Behavioural supervisory master that polls the controller over the serial channel
`timescale 1ns/100ps
`default_nettype none
module cycle_timer_master_model (
	input wire logic aclk,
	input wire logic serve_network,
	input wire logic [4:0] station_address,
	output logic poll_q
);
	// Highest station the master polls; 29 drops sit on one channel
	localparam logic [4:0] LAST_STATION = 5'h1e;
	// The master always opens the exchange and the controller only answers
	always_ff @(posedge aclk)
	begin
		// Poll only stations 2..30 and only while the slave serves the network
		poll_q <= serve_network && station_address >= 5'h02 && station_address <= LAST_STATION;
	end
endmodule : cycle_timer_master_model
`default_nettype wire

// ### test_cycle_timer_and_comm_setup.sv
// Self-checking bench for the cycle scheduler and settings panel
`timescale 1ns/100ps
`default_nettype none
module test_cycle_timer_and_comm_setup;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00; // Bus address lines
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid;
	logic [4:0] key_pins = 5'h00; // Panel keys, 1 = pressed
	logic protect_sw = 1'b0; // Memory-protect switch, 1 = writable
	logic ind, st, sn, sa, poll;
	logic [4:0] phs, addr;
	logic [2:0] rate;
	logic [1:0] page;
	logic [7:0] dval;
	logic [31:0] r;
	logic [1:0] rs;
	int n_mismatch = 0, checks_done = 0, wd = 0, n;
	// 25 MHz clock
	always #20 aclk = ~aclk;
	// Short counts keep the run small: 1 ms = 10 clocks, idle limit 200 clocks
	cycle_timer_and_comm_setup #(.TIMEOUT_CYCLES(200), .MS_CYCLES(10)) dut (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .page_key(key_pins[cycle_timer_pkg::K_PAGE]),
		.up_key(key_pins[cycle_timer_pkg::K_UP]), .down_key(key_pins[cycle_timer_pkg::K_DOWN]),
		.confirm_key(key_pins[cycle_timer_pkg::K_CONFIRM]),
		.settings_toggle_key(key_pins[cycle_timer_pkg::K_TOGGLE]), .memory_protect_switch(protect_sw),
		.cycle_period_indicator(ind), .phase_strobe(phs), .station_address(addr),
		.line_rate_sel(rate), .serve_terminal(st), .serve_network(sn), .settings_active(sa),
		.display_page(page), .display_value(dval));
	cycle_timer_master_model master (.aclk(aclk), .serve_network(sn), .station_address(addr),
		.poll_q(poll));
	// Watchdog: the whole run needs well under this many clocks
	always @(posedge aclk)
	begin
		wd <= wd + 1;
		if (wd == 90000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Write with both halves offered together; each released when taken
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		// Let an edge pass so a following call never drives bready twice in one step
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		// Let an edge pass so a following call never drives rready twice in one step
		@(posedge aclk);
	endtask : axi_rd
	// A press outlasts the three-edge key synchroniser
	task automatic press(input int k);
		key_pins[k] <= 1'b1;
		repeat (6) @(posedge aclk);
		key_pins[k] <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : press
	task automatic t_regs;
		axi_rd(6'h00, r, rs);
		chk(r, 32'h0014_0601);
		axi_wr(6'h00, 32'h0014_061f, rs);
		axi_rd(6'h00, r, rs);
		chk(r[4:0], 32'h1e);
		axi_wr(6'h10, 32'h0, rs);
		chk(rs, cycle_timer_pkg::RESP_SLVERR);
		axi_rd(6'h11, r, rs);
		chk(rs, cycle_timer_pkg::RESP_SLVERR);
		$display("test regs done");
	endtask : t_regs
	task automatic t_comm;
		// Address changed while communication is off
		axi_wr(6'h00, 32'h0014_0605, rs);
		axi_wr(6'h04, 32'h7, rs);
		@(posedge aclk);
		chk({st, sn}, 2'b00);
		axi_wr(6'h04, 32'hf, rs);
		@(posedge aclk);
		@(posedge aclk);
		chk({st, sn, poll}, 3'b011);
		// Status: address 5, network served, blocks complete, normal mode
		axi_rd(6'h08, r, rs);
		chk(r, 32'h0000_00c5);
		$display("test comm done");
	endtask : t_comm
	task automatic t_panel;
		press(cycle_timer_pkg::K_TOGGLE);
		press(cycle_timer_pkg::K_CONFIRM);
		chk(sa, 1'b0);
		protect_sw <= 1'b1;
		press(cycle_timer_pkg::K_TOGGLE);
		press(cycle_timer_pkg::K_CONFIRM);
		chk({sa, page}, 3'b100);
		key_pins[cycle_timer_pkg::K_CONFIRM] <= 1'b1;
		// Confirm goes down first, then the arrow key while it is held
		@(posedge aclk);
		press(cycle_timer_pkg::K_DOWN);
		chk({addr, st, sn}, 7'h06);
		press(cycle_timer_pkg::K_UP);
		key_pins[cycle_timer_pkg::K_CONFIRM] <= 1'b0;
		repeat (6) @(posedge aclk);
		chk({addr, dval, sn}, 14'h0a0b);
		press(cycle_timer_pkg::K_PAGE);
		chk(page, 2'h1);
		press(cycle_timer_pkg::K_UP);
		press(cycle_timer_pkg::K_UP);
		chk(rate, 3'h7);
		press(cycle_timer_pkg::K_PAGE);
		press(cycle_timer_pkg::K_DOWN);
		chk({page, dval}, 10'h2c3);
		repeat (190) @(posedge aclk);
		chk(sa, 1'b1);
		repeat (30) @(posedge aclk);
		chk(sa, 1'b0);
		$display("test panel done");
	endtask : t_panel
	task automatic t_cycle;
		// Shortest period, 100 ms = 1000 clocks here
		axi_wr(6'h00, 32'h0000_0605, rs);
		while (phs !== 5'h01) @(posedge aclk);
		for (int i = 1; i < 5; i++)
		begin
			@(posedge aclk);
			chk(phs, 32'h1 << i);
		end
		while (ind !== 1'b1) @(posedge aclk);
		n = 0;
		while (ind === 1'b1)
		begin
			@(posedge aclk);
			n++;
		end
		chk(n, 1000);
		n = 0;
		while (ind === 1'b0)
		begin
			@(posedge aclk);
			n++;
		end
		chk(n, 9000);
		// The second rise of the indicator marks twenty completed cycles
		axi_rd(6'h0c, r, rs);
		chk(r, 32'h0000_0014);
		$display("test cycle done");
	endtask : t_cycle
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_comm();
		t_panel();
		t_cycle();
		test_done();
	end
endmodule : test_cycle_timer_and_comm_setup
`default_nettype wire
